// *** logic/crq_pkg.sv ***
// Purpose: Shared constants and carrier types for the completer request stream port
// Assumes: One clock domain, APB register access, 32-bit register words
// Notes:   Sideband struct order gives the bit positions of the 88-bit vector
package crq_pkg;

    // ----------------------------------------------------------------
    // Stream geometry
    // ----------------------------------------------------------------
    localparam int          MAX_WIDTH     = 256;
    localparam int          MAX_LANES     = 8;
    localparam int          MAX_BYTES     = 32;
    localparam int          SIDEBAND_W    = 88;
    localparam logic [5:0]  CREDIT_MAX    = 6'h20;
    localparam logic [1:0]  GRANT_NONE    = 2'h0;

    // ----------------------------------------------------------------
    // Register map (byte addresses, low address bits decoded)
    // ----------------------------------------------------------------
    localparam int          REG_ADDR_W    = 8;
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_STATUS    = 8'h04;
    localparam logic [7:0]  REG_POSTED    = 8'h08;
    localparam logic [7:0]  REG_NONPOSTED = 8'h0C;
    localparam logic        CTRL_RESET    = 1'h1;
    localparam int          STAT_LINK_BIT = 8;
    localparam int          STAT_BUSY_BIT = 9;
    localparam int          STAT_NP_BIT   = 10;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SRC_IDLE      = 3'h1,
        SRC_POSTED    = 3'h2,
        SRC_NONPOSTED = 3'h4
    } crq_src_t;

    typedef struct packed {
        logic [2:0]  reserved;
        logic [31:0] parity;
        logic [7:0]  hint_steering_tag;
        logic [1:0]  hint_type;
        logic        hint_present;
        logic        discontinue;
        logic        start;
        logic [31:0] byte_valid;
        logic [3:0]  final_dword_byte_mask;
        logic [3:0]  first_dword_byte_mask;
    } crq_sideband_t;

    typedef struct packed {
        logic [255:0] data;
        logic [7:0]   dword_keep;
        logic [31:0]  byte_valid;
        logic [3:0]   first_dword_byte_mask;
        logic [3:0]   final_dword_byte_mask;
        logic         full_masks;
        logic         short_transfer;
        logic         zero_length;
        logic         has_payload;
        logic         hint_present;
        logic [1:0]   hint_type;
        logic [7:0]   hint_steering_tag;
        logic         payload_error;
        logic         last;
    } crq_beat_t;

    typedef struct packed {
        logic          out_valid;
        logic [255:0]  out_data;
        logic [7:0]    out_keep;
        crq_sideband_t out_side;
        logic          out_end;
        crq_src_t      sel;
        logic          last_np;
        logic [5:0]    credit;
        logic [5:0]    level;
        logic          enable;
        logic [15:0]   posted_cnt;
        logic [15:0]   np_cnt;
        logic          pready;
        logic [31:0]   prdata;
        logic          pslverr;
    } crq_state_t;

endpackage

// *** logic/crq_completer_request_port.sv ***
// Purpose: Delivers received requests to user logic on the completer request stream
// Assumes: Posted and non-posted sources feed whole packets beat after beat
// Notes:   Overview of operation below; APB holds enable, status and packet counts
//
// Overview of operation
// - Data lines above configured width held zero
// - 88-bit sideband accompanies data while valid
// - End flag on final beat of packet
// - Dword keep contiguous, full except final beat
// - Keep bits above configured lanes held zero
// - Valid stays high through whole packet
// - Hold beat stable until ready accepts it
// - Nonzero grant code adds one credit
// - Non-posted delivery consumes credit, stops at zero
// - Posted packets flow while non-posted paused
// - Grants accepted any cycle, unaligned to packets
// - Credit level output, saturating at 32
// - Credit cleared by reset or link down
// - First dword mask, ones for atomics/messages
// - Final mask ones or zero per request kind
// - Byte flags mark payload bytes only
// - Start bit on first beat
// - Discontinue only with end and payload error
// - Hint presence, type and steering tag
// - Odd parity per byte, upper bits zero
// - Sideband bits 87 to 85 unused
`timescale 1ns/1ns

module crq_completer_request_port #(
    parameter int STREAM_WIDTH = 256
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  link_up,
    input  wire crq_pkg::crq_beat_t    posted_beat,
    input  wire logic                  posted_valid,
    output logic                       posted_ready,
    input  wire crq_pkg::crq_beat_t    nonposted_beat,
    input  wire logic                  nonposted_valid,
    output logic                       nonposted_ready,
    output logic      [255:0]          request_stream_data,
    output crq_pkg::crq_sideband_t     request_stream_sideband,
    output logic                       request_stream_end,
    output logic      [7:0]            request_stream_dword_keep,
    output logic                       request_stream_valid,
    input  wire logic                  request_stream_ready,
    input  wire logic [1:0]            nonposted_credit_grant,
    output logic      [5:0]            nonposted_credit_level
);

    // ----------------------------------------------------------------
    // Width masks
    // ----------------------------------------------------------------
    localparam int           LANES     = STREAM_WIDTH / 32;
    localparam int           BYTES     = STREAM_WIDTH / 8;
    localparam logic [255:0] DATA_MASK = {256{1'b1}} >> (crq_pkg::MAX_WIDTH - STREAM_WIDTH);
    localparam logic [7:0]   KEEP_MASK = 8'hFF >> (crq_pkg::MAX_LANES - LANES);
    localparam logic [31:0]  BYTE_MASK = 32'hFFFFFFFF >> (crq_pkg::MAX_BYTES - BYTES);

    crq_pkg::crq_state_t s_q;
    crq_pkg::crq_state_t s_d;
    logic [31:0]         posted_par;
    logic [31:0]         np_par;

    // ----------------------------------------------------------------
    // Byte parity for both sources
    // ----------------------------------------------------------------
    // Parity is formed on each used byte of the source data; bits for unused upper bytes are tied zero
    for (genvar i = 0; i < crq_pkg::MAX_BYTES; i++) begin : g_par
        if (i < BYTES) begin : g_used
            assign posted_par[i] = ~^posted_beat.data[8*i +: 8];
            assign np_par[i]     = ~^nonposted_beat.data[8*i +: 8];
        end else begin : g_unused
            assign posted_par[i] = 1'b0;
            assign np_par[i]     = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        crq_pkg::crq_beat_t     beat;
        crq_pkg::crq_src_t      pick;
        crq_pkg::crq_sideband_t side;
        logic                   can_load;
        logic                   start;
        logic                   take;
        logic                   inc;
        logic                   dec;
        logic                   access;
        logic [31:0]            par;
        logic [7:0]             reg_addr;
        s_d             = s_q;
        beat            = posted_beat;
        par             = posted_par;
        side            = '0;
        start           = 1'b0;
        take            = 1'b0;
        can_load        = 1'b0;
        inc             = 1'b0;
        dec             = 1'b0;
        posted_ready    = 1'b0;
        nonposted_ready = 1'b0;
        pick            = s_q.sel;
        reg_addr        = paddr[crq_pkg::REG_ADDR_W-1:0];
        access          = psel && !penable;

        // The output stage is a single register: it frees when the user takes it
        can_load = !s_q.out_valid || request_stream_ready;
        if (s_q.out_valid && request_stream_ready) begin
            s_d.out_valid = 1'b0;
        end

        // New packets only start between packets; non-posted needs credit
        // and alternates with posted so neither starves the other
        if (s_q.sel == crq_pkg::SRC_IDLE && can_load && s_q.enable && link_up) begin
            if (nonposted_valid && s_q.credit != '0 &&
                (!posted_valid || !s_q.last_np)) begin
                pick  = crq_pkg::SRC_NONPOSTED;
                start = 1'b1;
            end else if (posted_valid) begin
                pick  = crq_pkg::SRC_POSTED;
                start = 1'b1;
            end
        end

        unique case (pick)
            crq_pkg::SRC_POSTED: begin
                beat         = posted_beat;
                par          = posted_par;
                take         = can_load && posted_valid;
                posted_ready = can_load;
            end
            crq_pkg::SRC_NONPOSTED: begin
                beat            = nonposted_beat;
                par             = np_par;
                take            = can_load && nonposted_valid;
                nonposted_ready = can_load;
            end
            crq_pkg::SRC_IDLE: begin
                take = 1'b0;
            end
            default: begin
                take = 1'b0;
            end
        endcase

        // Sideband assembly
        side.first_dword_byte_mask = beat.full_masks ? 4'hF
                                   : beat.first_dword_byte_mask;
        side.final_dword_byte_mask = beat.full_masks ? 4'hF
                                   : beat.short_transfer ? 4'h0
                                   : beat.final_dword_byte_mask;
        side.byte_valid   = beat.zero_length ? 32'h0
                          : (beat.byte_valid & BYTE_MASK);
        side.start        = start;
        side.discontinue  = beat.payload_error && beat.last
                          && beat.has_payload;
        side.hint_present      = beat.hint_present;
        side.hint_type         = beat.hint_type;
        side.hint_steering_tag = beat.hint_steering_tag;
        side.parity       = par;
        side.reserved     = 3'h0;

        // A beat loads only when the stage is free, so a held beat never moves
        if (take) begin
            s_d.out_valid = 1'b1;
            s_d.out_data  = beat.data & DATA_MASK;
            s_d.out_keep  = beat.dword_keep & KEEP_MASK;
            s_d.out_side  = side;
            s_d.out_end   = beat.last;
            s_d.sel       = beat.last ? crq_pkg::SRC_IDLE : pick;
            if (start) begin
                s_d.last_np = (pick == crq_pkg::SRC_NONPOSTED);
                if (pick == crq_pkg::SRC_NONPOSTED) begin
                    s_d.np_cnt = s_q.np_cnt + 16'h1;
                end else begin
                    s_d.posted_cnt = s_q.posted_cnt + 16'h1;
                end
            end
        end

        // Credit counter: grants sampled every cycle regardless of packets
        inc = (nonposted_credit_grant != crq_pkg::GRANT_NONE);
        dec = take && start && (pick == crq_pkg::SRC_NONPOSTED);
        if (!link_up) begin
            s_d.credit = 6'h0;
        end else if (inc && !dec && s_q.credit < crq_pkg::CREDIT_MAX) begin
            s_d.credit = s_q.credit + 6'h1;
        end else if (dec && !inc) begin
            s_d.credit = s_q.credit - 6'h1;
        end
        // Level output trails the count by one cycle
        s_d.level = s_q.credit;

        // APB slave, no wait states: answer is prepared in the setup cycle
        s_d.pready  = access;
        s_d.pslverr = 1'b0;
        s_d.prdata  = 32'h0;
        if (access) begin
            unique case (reg_addr)
                crq_pkg::REG_CTRL: begin
                    s_d.prdata = {31'h0, s_q.enable};
                end
                crq_pkg::REG_STATUS: begin
                    s_d.prdata                         = {26'h0, s_q.credit};
                    s_d.prdata[crq_pkg::STAT_LINK_BIT] = link_up;
                    s_d.prdata[crq_pkg::STAT_BUSY_BIT] = (s_q.sel != crq_pkg::SRC_IDLE);
                    s_d.prdata[crq_pkg::STAT_NP_BIT]   = s_q.last_np;
                end
                crq_pkg::REG_POSTED: begin
                    s_d.prdata = {16'h0, s_q.posted_cnt};
                end
                crq_pkg::REG_NONPOSTED: begin
                    s_d.prdata = {16'h0, s_q.np_cnt};
                end
                default: begin
                    s_d.pslverr = 1'b1;
                end
            endcase
        end
        // Writes land on the completing edge only; other registers are read-only
        if (psel && penable && s_q.pready && pwrite && !s_q.pslverr &&
            reg_addr == crq_pkg::REG_CTRL) begin
            s_d.enable = pwdata[0];
        end
        if (s_q.pready) begin
            s_d.pready  = 1'b0;
            s_d.pslverr = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q        <= '0;
            s_q.sel    <= crq_pkg::SRC_IDLE;
            s_q.enable <= crq_pkg::CTRL_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign request_stream_data       = s_q.out_data;
    assign request_stream_sideband   = s_q.out_side;
    assign request_stream_end        = s_q.out_end;
    assign request_stream_dword_keep = s_q.out_keep;
    assign request_stream_valid      = s_q.out_valid;
    assign nonposted_credit_level    = s_q.level;
    assign prdata                    = s_q.prdata;
    assign pready                    = s_q.pready;
    assign pslverr                   = s_q.pslverr;

endmodule

// *** dv/crq_cq_properties.sv ***
// Purpose: Port checks for the completer request stream
// Assumes: One clock domain, reset active low
// Notes:   Bound into the port module, watches its ports only
`timescale 1ns/1ns

module crq_cq_properties #(
    parameter int STREAM_WIDTH = 256
) (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   link_up,
    input wire logic [255:0]           request_stream_data,
    input wire crq_pkg::crq_sideband_t request_stream_sideband,
    input wire logic                   request_stream_end,
    input wire logic [7:0]             request_stream_dword_keep,
    input wire logic                   request_stream_valid,
    input wire logic                   request_stream_ready,
    input wire logic [5:0]             nonposted_credit_level
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    logic [31:0] par_exp;
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            par_exp[i] = (i < STREAM_WIDTH / 8) && !(^request_stream_data[8*i+:8]);
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_stalled;
        request_stream_valid && !request_stream_ready;
    endsequence
    sequence s_mid_taken;
        request_stream_valid && request_stream_ready && !request_stream_end;
    endsequence
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_stall_hold: assert property (s_stalled |=> request_stream_valid &&
        $stable(request_stream_data) && $stable(request_stream_sideband)
        && $stable(request_stream_end)) else $error("beat changed while stalled");
    a_packet_unbroken: assert property (s_mid_taken |=> request_stream_valid)
        else $error("valid dropped inside packet");
    a_start_marks: assert property (request_stream_valid && request_stream_ready |=>
        !request_stream_valid || request_stream_sideband.start == $past(request_stream_end))
        else $error("start flag misplaced");
    a_discont_end: assert property (request_stream_valid &&
        request_stream_sideband.discontinue |-> request_stream_end) else $error("abort off end");
    a_spare_zero: assert property (request_stream_sideband.reserved == 3'h0)
        else $error("spare sideband bits set");
    a_wide_zero: assert property ((request_stream_data >> STREAM_WIDTH) == 256'h0 &&
        (request_stream_dword_keep >> (STREAM_WIDTH / 32)) == 8'h00) else $error("upper lanes set");
    a_parity_odd: assert property (request_stream_valid |->
        request_stream_sideband.parity == par_exp) else $error("parity wrong");
    a_flags_width: assert property (request_stream_valid |->
        (request_stream_sideband.byte_valid >> (STREAM_WIDTH / 8)) == 32'h0)
        else $error("byte flags above width");
    a_keep_full: assert property (request_stream_valid |-> request_stream_dword_keep != 8'h00 &&
        ((request_stream_dword_keep + 8'h01) & request_stream_dword_keep) == 8'h00 &&
        (request_stream_end || request_stream_dword_keep == (8'hFF >> (8 - STREAM_WIDTH / 32))))
        else $error("keep not contiguous");
    a_level_cap: assert property (nonposted_credit_level <= 6'h20)
        else $error("credit above cap");
    a_level_step: assert property (1'b1 |=>
        nonposted_credit_level <= $past(nonposted_credit_level) + 6'h01) else $error("credit jump");
    a_link_clear: assert property (!link_up |-> ##2 nonposted_credit_level == 6'h00)
        else $error("credit kept over link down");
endmodule

bind crq_completer_request_port crq_cq_properties #(.STREAM_WIDTH(STREAM_WIDTH)) i_props (
    .pclk(pclk), .presetn(presetn), .link_up(link_up),
    .request_stream_data(request_stream_data), .request_stream_sideband(request_stream_sideband),
    .request_stream_end(request_stream_end), .request_stream_dword_keep(request_stream_dword_keep),
    .request_stream_valid(request_stream_valid), .request_stream_ready(request_stream_ready),
    .nonposted_credit_level(nonposted_credit_level));

// *** dv/crq_user_model.sv ***
// Purpose: User logic that takes completer requests
// Assumes: Ready answers at once, or every other cycle when slow
// Notes:   Counts kept and dropped packets, keeps the last start beat sideband
`timescale 1ns/1ns

module crq_user_model (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   slow,
    input  wire logic [1:0]             grant_req,
    input  wire logic                   request_stream_valid,
    input  wire logic                   request_stream_end,
    input  wire crq_pkg::crq_sideband_t request_stream_sideband,
    output logic                        request_stream_ready,
    output logic [1:0]                  nonposted_credit_grant,
    output logic [7:0]                  kept,
    output logic [7:0]                  dropped,
    output crq_pkg::crq_sideband_t      sop_side
);
    logic tog;
    // Grants go out whenever asked, with no regard to packet edges
    assign nonposted_credit_grant = grant_req;
    assign request_stream_ready = !slow || tog;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tog <= 1'b0;
            kept <= 8'h00;
            dropped <= 8'h00;
            sop_side <= '0;
        end else begin
            tog <= !tog;
            if (request_stream_valid && request_stream_ready) begin
                if (request_stream_sideband.start) sop_side <= request_stream_sideband;
                if (request_stream_end && request_stream_sideband.discontinue) begin
                    dropped <= dropped + 8'h01;
                end else if (request_stream_end) begin
                    kept <= kept + 8'h01;
                end
            end
        end
    end
endmodule

// *** dv/tb.sv ***
// Purpose: Directed bench for the completer request stream port
// Assumes: Default stream width, user logic model on the far side
// Notes:   Waits are bounded; a spent bound ends the run as a failure
`timescale 1ns/1ns

module tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
    logic pready, pslverr, link_up = 1'b1, slow = 1'b0, pv = 1'b0, nv = 1'b0, pr, nr;
    crq_pkg::crq_beat_t pb = '0, nb = '0, b;
    crq_pkg::crq_sideband_t ss, sop;
    logic [255:0] sd;
    logic se, sv, srdy;
    logic [7:0] sk, kept, dropped;
    logic [1:0] greq = 2'h0, grant;
    logic [5:0] lvl;
    int num_errors = 0, checks_done = 0;
    always #5 pclk = ~pclk;
    crq_completer_request_port i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link_up(link_up), .posted_beat(pb),
        .posted_valid(pv), .posted_ready(pr), .nonposted_beat(nb), .nonposted_valid(nv),
        .nonposted_ready(nr), .request_stream_data(sd), .request_stream_sideband(ss),
        .request_stream_end(se), .request_stream_dword_keep(sk), .request_stream_valid(sv),
        .request_stream_ready(srdy), .nonposted_credit_grant(grant), .nonposted_credit_level(lvl));
    crq_user_model i_user (.pclk(pclk), .presetn(presetn), .slow(slow), .grant_req(greq),
        .request_stream_valid(sv), .request_stream_end(se), .request_stream_sideband(ss),
        .request_stream_ready(srdy), .nonposted_credit_grant(grant), .kept(kept),
        .dropped(dropped), .sop_side(sop));
    task automatic give_verdict();
        $display("Checks %0d, errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic look(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask
    // ----------------------------------------
    // Bus and source drivers
    // ----------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // Answer is taken at the rising edge that samples pready high
        do begin @(posedge pclk); n++; end while (!pready && n < 50);
        if (!pready) begin num_errors++; give_verdict(); end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic send(input logic np, input crq_pkg::crq_beat_t c, input int beats);
        int n;
        @(posedge pclk);
        for (int i = 0; i < beats; i++) begin
            c.last = (i == beats - 1);
            c.data[7:0] = 8'(i);
            if (np) begin nb <= c; nv <= 1'b1; end
            else begin pb <= c; pv <= 1'b1; end
            n = 0;
            do begin @(negedge pclk); n++; end while (!(np ? nr : pr) && n < 100);
            if (n >= 100) begin num_errors++; give_verdict(); end
            @(posedge pclk);
        end
        if (np) nv <= 1'b0;
        else pv <= 1'b0;
    endtask
    initial begin
        logic [31:0] q;
        logic e;
        int n;
        b = '0;
        b.dword_keep = 8'hFF;
        b.byte_valid = 32'hFFFF_FFFF;
        b.has_payload = 1'b1;
        b.first_dword_byte_mask = 4'h3;
        b.final_dword_byte_mask = 4'hC;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, crq_pkg::REG_CTRL, 32'h0, q, e);
        check(q, 32'h1);
        apb(1'b0, 8'h10, 32'h0, q, e);
        check(e, 32'h1);
        @(posedge pclk);
        // Every grant code once, an idle code between them
        for (int c = 1; c < 4; c++) begin
            greq <= 2'(c);
            @(posedge pclk);
            greq <= 2'h0;
            @(posedge pclk);
        end
        look(3);
        check(lvl, 32'h3);
        send(1'b1, b, 2);
        look(5);
        check(lvl, 32'h2);
        check(kept, 32'h1);
        @(posedge pclk);
        greq <= 2'h3;
        repeat (40) @(posedge pclk);
        greq <= 2'h0;
        look(3);
        check(lvl, 32'h20);
        @(posedge pclk);
        link_up <= 1'b0;
        repeat (2) @(posedge pclk);
        link_up <= 1'b1;
        look(3);
        check(lvl, 32'h0);
        // Non-posted waits without credit while posted passes it
        @(posedge pclk);
        b.last = 1'b1;
        nb <= b;
        nv <= 1'b1;
        send(1'b0, b, 1);
        look(4);
        check(kept, 32'h2);
        check(nr, 32'h0);
        @(posedge pclk);
        greq <= 2'h1;
        @(posedge pclk);
        greq <= 2'h0;
        // The waiting request is held until the new credit lets it through
        n = 0;
        do begin @(posedge pclk); n++; end while (!nr && n < 100);
        if (!nr) begin num_errors++; give_verdict(); end
        nv <= 1'b0;
        look(4);
        check(kept, 32'h3);
        b.full_masks = 1'b1;
        b.hint_present = 1'b1;
        b.hint_type = 2'h2;
        b.hint_steering_tag = 8'hA5;
        send(1'b0, b, 1);
        look(4);
        check({sop.first_dword_byte_mask, sop.final_dword_byte_mask}, 32'hFF);
        check({sop.hint_present, sop.hint_type, sop.hint_steering_tag}, 32'h6A5);
        b.full_masks = 1'b0;
        b.short_transfer = 1'b1;
        b.zero_length = 1'b1;
        send(1'b0, b, 1);
        look(4);
        check({sop.first_dword_byte_mask, sop.final_dword_byte_mask}, 32'h30);
        check(sop.byte_valid, 32'h0);
        b.short_transfer = 1'b0;
        b.zero_length = 1'b0;
        b.payload_error = 1'b1;
        slow <= 1'b1;
        send(1'b0, b, 3);
        look(8);
        check({kept, dropped}, 32'h0501);
        apb(1'b0, crq_pkg::REG_STATUS, 32'h0, q, e);
        check(q[crq_pkg::STAT_LINK_BIT], 32'h1);
        give_verdict();
    end
endmodule
